/* hdl/uart_irq_enable_baud_gen.sv */
/*
 * Interrupt enable, interrupt identification, baud divisor and scratch
 * registers of a serial port, reached over APB, plus the 16x clock generator.
 * Assumes pclk is the 24 MHz reference and sources are synchronous levels.
 */
// How it works
// - Enable bits 7 to 4 read zero
// - Bit 3 gates modem status interrupt
// - Bit 2 gates line status interrupt
// - Bit 1 gates transmit empty interrupt
// - Bit 0 gates receive ready interrupt
// - All enables clear means no interrupt
// - Eight-bit enable register, independent bits
// - Divisor from two bytes, 1 to 65535
// - Normal mode pre-divides reference, then divisor
// - Divider output is common 16x timing base
// - High speed feeds reference straight to divisor
// - High speed divisor one gives 1.5M bps
// - Pre-divider selects 13, 1.625 or 1
// - Scratch register returns last written value
// - Master enable gates output; loopback feeds carrier
// - Identification reports highest priority pending source
`timescale 1ns/1ps
module uart_irq_enable_baud_gen (
    input wire logic pclk, // 24 MHz reference clock
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic rx_ready, // Receive data ready or FIFO trigger
    input wire logic rx_timeout, // Receive FIFO timeout
    input wire logic tx_empty, // Transmit holding empty
    input wire logic line_status, // Receive line status error pending
    input wire logic modem_status, // Modem status change pending
    input wire logic fifo_mode, // FIFO mode enabled
    output logic port_irq, // Port interrupt output
    output logic block_irq, // Event interrupt output
    output logic baud_tick, // 16x clock pulse
    output logic carrier_loop // Master enable looped to carrier input
);
    logic [7:0] interrupt_enable_reg;
    logic [7:0] baud_divisor_low;
    logic [7:0] baud_divisor_high;
    logic [7:0] scratch_reg;
    logic [4:0] cfg;
    logic [1:0] events;
    logic [1:0] event_mask;
    logic [4:0] prediv_acc;
    logic prediv_tick;
    logic [15:0] div_count;
    logic tx_empty_d;

    // Bus decode
    wire setup = psel && !penable;
    wire wr = psel && penable && pwrite;
    wire hit_ie = paddr == uart_irq_baud_pkg::irq_enable_addr;
    wire hit_dl = paddr == uart_irq_baud_pkg::div_low_addr;
    wire hit_dh = paddr == uart_irq_baud_pkg::div_high_addr;
    wire hit_sc = paddr == uart_irq_baud_pkg::scratch_addr;
    wire hit_cf = paddr == uart_irq_baud_pkg::config_addr;
    wire hit_is = paddr == uart_irq_baud_pkg::irq_status_addr;
    wire hit_ev = paddr == uart_irq_baud_pkg::event_addr;
    wire hit_em = paddr == uart_irq_baud_pkg::event_mask_addr;
    wire hit_src = paddr == uart_irq_baud_pkg::source_addr;
    wire mapped = hit_ie | hit_dl | hit_dh | hit_sc | hit_cf | hit_is | hit_ev | hit_em
        | hit_src;

    // Configuration fields
    wire high_speed = cfg[uart_irq_baud_pkg::high_speed_bit];
    wire [1:0] prediv_sel = cfg[uart_irq_baud_pkg::predivider_lsb +: 2];
    wire master_irq_en = cfg[uart_irq_baud_pkg::master_irq_bit];
    wire loopback = cfg[uart_irq_baud_pkg::loopback_bit];

    // Gated interrupt sources
    wire en_rx = interrupt_enable_reg[uart_irq_baud_pkg::rx_ready_bit];
    wire en_tx = interrupt_enable_reg[uart_irq_baud_pkg::tx_empty_bit];
    wire en_ls = interrupt_enable_reg[uart_irq_baud_pkg::line_status_bit];
    wire en_ms = interrupt_enable_reg[uart_irq_baud_pkg::modem_status_bit];
    wire g_ls = en_ls && line_status;
    wire g_to = en_rx && rx_timeout && fifo_mode;
    wire g_rx = en_rx && rx_ready;
    wire g_tx = en_tx && tx_empty;
    wire g_ms = en_ms && modem_status;
    wire any_pending = g_ls | g_to | g_rx | g_tx | g_ms;
    // In loopback the master enable leaves the pin and drives carrier
    wire next_port_irq = any_pending && master_irq_en && !loopback;

    // Priority identification, line status highest
    wire [3:0] irq_id = g_ls ? uart_irq_baud_pkg::id_line :
        g_to ? uart_irq_baud_pkg::id_timeout :
        g_rx ? uart_irq_baud_pkg::id_rx :
        g_tx ? uart_irq_baud_pkg::id_tx :
        g_ms ? uart_irq_baud_pkg::id_modem : uart_irq_baud_pkg::id_none;
    wire [7:0] irq_status_val = {fifo_mode, fifo_mode, 2'h0, irq_id};

    // Divisor and 16x generation
    wire [15:0] divisor = {baud_divisor_high, baud_divisor_low};
    wire [15:0] div_load = (divisor == 16'h0000) ? 16'h0001 : divisor;
    wire [4:0] prediv_inc = (prediv_sel == uart_irq_baud_pkg::prediv_1p625) ?
        uart_irq_baud_pkg::prediv_1p625_inc : uart_irq_baud_pkg::prediv_13_inc;
    wire [4:0] prediv_sum = prediv_acc + prediv_inc;
    wire prediv_wrap = prediv_sum >= uart_irq_baud_pkg::prediv_13_num;
    wire [4:0] next_prediv_acc = prediv_wrap ?
        prediv_sum - uart_irq_baud_pkg::prediv_13_num : prediv_sum;
    // High speed or pre-divide of one passes every reference cycle
    wire bypass = high_speed || (prediv_sel == uart_irq_baud_pkg::prediv_1);
    wire ref_tick = bypass ? 1'b1 : prediv_tick;
    wire div_end = ref_tick && (div_count <= 16'h0001);
    wire [15:0] next_div_count = div_end ? div_load : div_count - 16'h0001;

    // Events: tx empty rising edge, unmapped bus access
    wire tx_rise = tx_empty && !tx_empty_d;
    wire bad_access = psel && penable && !mapped;
    wire [1:0] event_set = {bad_access, tx_rise};
    wire [1:0] event_clr = (wr && hit_ev) ? pwdata[1:0] : 2'h0;

    // Read multiplexer
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (hit_ie) rd_byte = {4'h0, interrupt_enable_reg[3:0]};
        if (hit_dl) rd_byte = baud_divisor_low;
        if (hit_dh) rd_byte = baud_divisor_high;
        if (hit_sc) rd_byte = scratch_reg;
        if (hit_cf) rd_byte = {3'h0, cfg};
        if (hit_is) rd_byte = irq_status_val;
        if (hit_ev) rd_byte = {6'h00, events};
        if (hit_em) rd_byte = {6'h00, event_mask};
        if (hit_src) rd_byte = {3'h0, modem_status, line_status, tx_empty, rx_timeout, rx_ready};
    end

    // APB answer: no wait state, data registered in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= setup && !pwrite ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // Software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_enable_reg <= uart_irq_baud_pkg::irq_enable_reset;
            baud_divisor_low <= uart_irq_baud_pkg::div_low_reset;
            baud_divisor_high <= uart_irq_baud_pkg::div_high_reset;
            scratch_reg <= uart_irq_baud_pkg::scratch_reset;
            cfg <= uart_irq_baud_pkg::config_reset;
            event_mask <= 2'h0;
        end else if (wr) begin
            if (hit_ie) interrupt_enable_reg <= pwdata[7:0] & {4'h0, 4'hf};
            if (hit_dl) baud_divisor_low <= pwdata[7:0];
            if (hit_dh) baud_divisor_high <= pwdata[7:0];
            if (hit_sc) scratch_reg <= pwdata[7:0];
            if (hit_cf) cfg <= pwdata[4:0];
            if (hit_em) event_mask <= pwdata[1:0];
        end
    end

    // Sticky events: set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            events <= 2'h0;
            tx_empty_d <= 1'b0;
        end else begin
            events <= (events & ~event_clr) | event_set;
            tx_empty_d <= tx_empty;
        end
    end

    // Fractional pre-divider and divisor counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prediv_acc <= 5'h00;
            prediv_tick <= 1'b0;
            div_count <= 16'h0001;
        end else begin
            prediv_acc <= next_prediv_acc;
            prediv_tick <= prediv_wrap;
            if (ref_tick) div_count <= next_div_count;
        end
    end

    // Registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_irq <= 1'b0;
            block_irq <= 1'b0;
            baud_tick <= 1'b0;
            carrier_loop <= 1'b0;
        end else begin
            port_irq <= next_port_irq;
            block_irq <= |(events & event_mask);
            baud_tick <= div_end;
            carrier_loop <= loopback && master_irq_en;
        end
    end
endmodule : uart_irq_enable_baud_gen

/* hdl/uart_irq_baud_pkg.sv */
/*
 * Constants for the serial port interrupt enable and baud generator block.
 * Assumes an APB slave with 32-bit data and word-aligned registers.
 */
package uart_irq_baud_pkg;
    // Register byte addresses
    localparam logic [7:0] irq_enable_addr = 8'h00;
    localparam logic [7:0] div_low_addr = 8'h04;
    localparam logic [7:0] div_high_addr = 8'h08;
    localparam logic [7:0] scratch_addr = 8'h0c;
    localparam logic [7:0] config_addr = 8'h10;
    localparam logic [7:0] irq_status_addr = 8'h14;
    localparam logic [7:0] event_addr = 8'h18;
    localparam logic [7:0] event_mask_addr = 8'h1c;
    localparam logic [7:0] source_addr = 8'h20;
    // Interrupt enable bit positions
    localparam int rx_ready_bit = 0;
    localparam int tx_empty_bit = 1;
    localparam int line_status_bit = 2;
    localparam int modem_status_bit = 3;
    localparam logic [3:0] irq_enable_mask = 4'hf;
    // Config bits
    localparam int high_speed_bit = 0;
    localparam int predivider_lsb = 1;
    localparam int master_irq_bit = 3;
    localparam int loopback_bit = 4;
    // Reset values
    localparam logic [7:0] irq_enable_reset = 8'h00;
    localparam logic [7:0] div_low_reset = 8'h01;
    localparam logic [7:0] div_high_reset = 8'h00;
    localparam logic [7:0] scratch_reset = 8'h00;
    localparam logic [4:0] config_reset = 5'h00;
    // Pre-divider selection codes
    localparam logic [1:0] prediv_13 = 2'h0;
    localparam logic [1:0] prediv_1p625 = 2'h1;
    localparam logic [1:0] prediv_1 = 2'h2;
    // Divide by 1.625 = 13/8: 8 output pulses per 13 input clocks
    localparam logic [4:0] prediv_13_num = 5'h0d;
    localparam logic [4:0] prediv_1p625_inc = 5'h08;
    localparam logic [4:0] prediv_13_inc = 5'h01;
    // Interrupt identification codes
    localparam logic [3:0] id_none = 4'h1;
    localparam logic [3:0] id_line = 4'h6;
    localparam logic [3:0] id_rx = 4'h4;
    localparam logic [3:0] id_timeout = 4'hc;
    localparam logic [3:0] id_tx = 4'h2;
    localparam logic [3:0] id_modem = 4'h0;
endpackage : uart_irq_baud_pkg

/* test/uart_irq_props.sv */
/* Checker for the serial port interrupt enable and baud block.
   Sees only the block's ports; bound to it at the foot. */
`timescale 1ns/1ps
module uart_irq_props (
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic psel, // select
    input wire logic penable, // access
    input wire logic pwrite, // write
    input wire logic [7:0] paddr, // address
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic rx_ready, // source
    input wire logic rx_timeout, // source
    input wire logic tx_empty, // source
    input wire logic line_status, // source
    input wire logic modem_status, // source
    input wire logic port_irq, // interrupt
    input wire logic carrier_loop // loopback carrier
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Pending source and completed read
    wire any_src = rx_ready | rx_timeout | tx_empty | line_status | modem_status;
    wire rd_end = psel & penable & pready & !pwrite;
    property p_ready_next; psel && !penable |=> pready; endproperty
    a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
    property p_err_ready; pslverr |-> pready && psel && penable; endproperty
    a_err_ready: assert property (p_err_ready) else $error("error outside access");
    property p_bad_addr; psel && penable && pready && paddr > 8'h20 |-> pslverr; endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("unmapped access accepted");
    property p_ier_upper; rd_end && paddr == 8'h00 |-> prdata[31:4] == 28'h0; endproperty
    a_ier_upper: assert property (p_ier_upper) else $error("enable upper bits set");
    property p_div_byte; rd_end && paddr inside {8'h04, 8'h08} |-> prdata[31:8] == 24'h0;
    endproperty
    a_div_byte: assert property (p_div_byte) else $error("divisor wider than byte");
    property p_scr_byte; rd_end && paddr == 8'h0c |-> prdata[31:8] == 24'h0; endproperty
    a_scr_byte: assert property (p_scr_byte) else $error("scratch wider than byte");
    property p_loop_quiet; carrier_loop |-> !port_irq; endproperty
    a_loop_quiet: assert property (p_loop_quiet) else $error("irq during loopback");
    property p_irq_cause; port_irq |-> $past(any_src); endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without source");
    // Main scenarios reached
    c_bad: cover property (pslverr);
    c_irq: cover property (port_irq);
    c_loop: cover property (carrier_loop);
endmodule : uart_irq_props
bind uart_irq_enable_baud_gen uart_irq_props uart_irq_props_i (.*);

/* test/uart_src_model.sv */
/* Model of the serial core beside the block: drives source levels.
   Assumes the bench asks for levels just after a rising edge. */
`timescale 1ns/1ps
module uart_src_model (
    input wire logic pclk, // clock
    input wire logic [4:0] src_req, // wanted levels
    input wire logic slow, // answer a cycle late
    output logic [4:0] src // levels to block
);
    logic [4:0] lag;
    // Late copy of the requested levels
    always_ff @(posedge pclk) begin
        lag <= src_req;
    end
    assign src = slow ? lag : src_req;
endmodule : uart_src_model

/* test/tb_top.sv */
/* Bench: APB master, source model, queued read expectations.
   Assumes the checker is bound to the block. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, fifo_mode = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, v;
    logic [4:0] src_req = 0, src;
    logic pready, pslverr, port_irq, block_irq, baud_tick, carrier_loop;
    logic [35:0] notes[$];
    integer seed = 32'h80f1;
    int num_errors = 0, check_count = 0, n;
    int rst_v[9] = '{0, 1, 0, 0, 0, 1, 0, 0, 0};
    int id_v[4] = '{4, 2, 6, 0};
    int pm[4] = '{15, 11, 10, 8};
    int pv[4] = '{6, 4, 2, 0};
    int cb[4] = '{1, 0, 2, 4};
    int ck[4] = '{2, 2, 8, 2};
    int cm[4] = '{2, 26, 13, 2};
    uart_irq_enable_baud_gen uart_irq_enable_baud_gen_i (.*, .rx_ready(src[0]), .tx_empty(src[1]),
        .line_status(src[2]), .modem_status(src[3]), .rx_timeout(src[4]), .fifo_mode(fifo_mode));
    uart_src_model uart_src_model_i (.pclk(pclk), .src_req(src_req), .slow(slow), .src(src));
    initial forever #25 pclk = ~pclk;
    // One APB transfer, then an idle cycle
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1, a, d);
    endtask : wr
    // Flags: error, carrier, port irq, event irq
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [3:0] f = 0);
        notes.push_back({f, e});
        xfer(0, a, 0);
    endtask : rd
    // Cycles spanned by k baud ticks
    task automatic per(input int k);
        n = 0;
        do @(posedge pclk); while (baud_tick !== 1'b1);
        repeat (k) do begin
            @(posedge pclk);
            n++;
        end while (baud_tick !== 1'b1);
    endtask : per
    // Compare each read with the oldest note
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1)
            `CHK("read", notes.pop_front(), {pslverr, carrier_loop, port_irq, block_irq, prdata})
    end
    task automatic give_verdict;
        if (num_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    initial begin
        #1000000;
        num_errors++;
        give_verdict();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        foreach (rst_v[i]) rd(8'(4 * i), rst_v[i]);
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(8'(4 * i), v);
            rd(8'(4 * i), v & (i ? 32'hff : 32'hf));
        end
        wr(8'h10, 8'h08);
        wr(8'h08, 0);
        // Each source but rx_timeout alone, passed or masked by its own bit
        for (int i = 0; i < 4; i++) begin
            src_req <= 5'(1 << i);
            slow <= i[0];
            wr(8'h00, 1 << i);
            rd(8'h14, id_v[i], 2);
            wr(8'h00, 4'hf ^ (1 << i));
            rd(8'h14, 1);
        end
        src_req <= 5'h1f;
        foreach (pm[i]) begin
            wr(8'h00, pm[i]);
            rd(8'h14, pv[i], 2);
        end
        // FIFO mode: timeout outranks receive ready, top status bits set
        fifo_mode <= 1;
        wr(8'h00, 1);
        rd(8'h14, 8'hcc, 2);
        wr(8'h00, 2);
        rd(8'h14, 8'hc2, 2);
        fifo_mode <= 0;
        wr(8'h00, 0);
        rd(8'h00, 0);
        wr(8'h00, 15);
        wr(8'h10, 8'h18);
        rd(8'h10, 8'h18, 4);
        wr(8'h10, 0);
        rd(8'h00, 15);
        // Sticky events, mask and clear
        src_req <= 0;
        wr(8'h18, 3);
        wr(8'h1c, 3);
        rd(8'h40, 0, 8);
        rd(8'h18, 2, 1);
        wr(8'h1c, 1);
        src_req <= 2;
        wr(8'h18, 0);
        rd(8'h18, 3, 1);
        wr(8'h18, 3);
        rd(8'h18, 0);
        // Baud period per pre-divider mode
        foreach (cb[i]) begin
            v = i ? 2 + $unsigned($random(seed)) % 4 : 1;
            wr(8'h10, cb[i]);
            wr(8'h04, v);
            per(1);
            per(ck[i]);
            `CHK("baud period", cm[i] * v, n)
        end
        give_verdict();
    end
endmodule : tb_top
